// >>> verilog/epdbw_top.sv
/*
  Command decoder for border control, read-RAM option and RAM X window,
  reached over an AXI4-Lite slave; CMD writes are opcodes, PARAM writes
  are parameter bytes. Assumes one clock, synchronous active-low reset.
*/
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module epdbw_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [1:0]       border_drive_sel,
  output logic [1:0]       border_fix_level,
  output logic [1:0]       border_table_sel,
  output logic             read_ram_sel,
  output logic [9:0]       x_window_start,
  output logic [9:0]       x_window_end
);

  // Unknown opcodes park the sequencer so stray parameters fall away
  function automatic epdbw_pkg::epdbw_state_e op_decode(input logic [7:0] op);
    case (op)
      epdbw_pkg::OP_BORDER: op_decode = epdbw_pkg::ST_BORDER;
      epdbw_pkg::OP_RAMOPT: op_decode = epdbw_pkg::ST_RAMOPT;
      epdbw_pkg::OP_XWIN:   op_decode = epdbw_pkg::ST_XWIN;
      default:              op_decode = epdbw_pkg::ST_IDLE;
    endcase
  endfunction

  function automatic logic [7:0] word_addr(input logic [7:0] a);
    word_addr = {a[7:2], 2'b00};
  endfunction

  logic                      aw_hold_q;
  logic                      w_hold_q;
  logic [7:0]                awaddr_q;
  logic [7:0]                wdata_q;
  logic                      wstrb0_q;
  logic                      awready_q;
  logic                      wready_q;
  logic                      bvalid_q;
  logic [1:0]                bresp_q;
  logic                      arready_q;
  logic                      rvalid_q;
  logic [31:0]               rdata_q;
  logic [1:0]                rresp_q;
  logic [7:0]                border_q;
  logic                      ramopt_q;
  logic [9:0]                x_start_position_q;
  logic [9:0]                x_end_position_q;
  epdbw_pkg::epdbw_state_e   state_q;
  epdbw_pkg::epdbw_state_e   state_d;
  logic [2:0]                idx_q;
  logic [2:0]                idx_d;

  // Write path decode
  wire        wr_fire  = aw_hold_q & w_hold_q & ~bvalid_q;
  wire [7:0]  wr_addr  = word_addr(awaddr_q);
  wire        wr_ok    = (wr_addr == epdbw_pkg::OFF_CMD) | (wr_addr == epdbw_pkg::OFF_PARAM);
  wire        cmd_stb  = wr_fire & wstrb0_q & (wr_addr == epdbw_pkg::OFF_CMD);
  wire        prm_stb  = wr_fire & wstrb0_q & (wr_addr == epdbw_pkg::OFF_PARAM);
  wire        aw_take  = s_axi_awvalid & awready_q;
  wire        w_take   = s_axi_wvalid & wready_q;
  wire        b_done   = bvalid_q & s_axi_bready;
  wire        ar_take  = s_axi_arvalid & arready_q;
  wire        r_done   = rvalid_q & s_axi_rready;

  // Parameter sequencing
  wire        prm_live = prm_stb & (state_q != epdbw_pkg::ST_IDLE);
  wire        prm_last = (state_q == epdbw_pkg::ST_BORDER) | (state_q == epdbw_pkg::ST_RAMOPT) |
                         ((state_q == epdbw_pkg::ST_XWIN) &&
                          (idx_q == 3'(epdbw_pkg::XWIN_PRMS - 1)));
  assign state_d = cmd_stb ? op_decode(wdata_q) :
                   (prm_live & prm_last) ? epdbw_pkg::ST_IDLE : state_q;
  assign idx_d   = cmd_stb ? 3'h0 : prm_live ? idx_q + 3'h1 : idx_q;

  wire        ld_border = prm_live & (state_q == epdbw_pkg::ST_BORDER);
  wire        ld_ramopt = prm_live & (state_q == epdbw_pkg::ST_RAMOPT);
  wire        ld_xwin   = prm_live & (state_q == epdbw_pkg::ST_XWIN);

  // Read decode
  wire [7:0]  rd_addr  = word_addr(s_axi_araddr);
  wire        rd_ok    = rd_addr <= epdbw_pkg::OFF_STATUS;
  wire [31:0] rd_mux   =
    (rd_addr == epdbw_pkg::OFF_BORDER) ? {24'h0, border_q} :
    (rd_addr == epdbw_pkg::OFF_RAMOPT) ? {31'h0, ramopt_q} :
    (rd_addr == epdbw_pkg::OFF_XWIN)   ? {6'h0, x_end_position_q, 6'h0, x_start_position_q} :
    (rd_addr == epdbw_pkg::OFF_STATUS) ? {25'h0, idx_q, state_q} : 32'h0;

  // AXI write channels
  // Ready stays low until the response is taken: one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= epdbw_pkg::RESP_OKAY;
      awaddr_q  <= 8'h00;
      wdata_q   <= 8'h00;
      wstrb0_q  <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_hold_q <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q  <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q  <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok ? epdbw_pkg::RESP_OKAY : epdbw_pkg::RESP_SLVERR;
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
      end
      if (b_done) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // AXI read channels
  // Arready returns with the response handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= epdbw_pkg::RESP_OKAY;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_ok ? rd_mux : 32'h0;
      rresp_q   <= rd_ok ? epdbw_pkg::RESP_OKAY : epdbw_pkg::RESP_SLVERR;
    end else if (r_done) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // Command sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= epdbw_pkg::ST_IDLE;
      idx_q   <= 3'h0;
    end else begin
      state_q <= state_d;
      idx_q   <= idx_d;
    end
  end

  // Settings latched from parameter bytes
  // Window bytes land one at a time, in arrival order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      border_q <= epdbw_pkg::BORDER_RST;
      ramopt_q <= epdbw_pkg::RAMOPT_RST;
      x_start_position_q <= epdbw_pkg::X_START_POSITION_RST;
      x_end_position_q   <= epdbw_pkg::X_END_POSITION_RST;
    end else begin
      if (ld_border)
        border_q <= wdata_q & epdbw_pkg::BORDER_MASK;
      if (ld_ramopt)
        ramopt_q <= wdata_q[0];
      if (ld_xwin) begin
        case (idx_q)
          3'h0:    x_start_position_q[7:0] <= wdata_q;
          3'h1:    x_start_position_q[9:8] <= wdata_q[1:0];
          3'h2:    x_end_position_q[7:0]   <= wdata_q;
          3'h3:    x_end_position_q[9:8]   <= wdata_q[1:0];
          default: x_end_position_q        <= x_end_position_q;
        endcase
      end
    end
  end

  assign s_axi_awready    = awready_q;
  assign s_axi_wready     = wready_q;
  assign s_axi_bvalid     = bvalid_q;
  assign s_axi_bresp      = bresp_q;
  assign s_axi_arready    = arready_q;
  assign s_axi_rvalid     = rvalid_q;
  assign s_axi_rdata      = rdata_q;
  assign s_axi_rresp      = rresp_q;
  assign border_drive_sel = border_q[epdbw_pkg::SRC_LO +: 2];
  assign border_fix_level = border_q[epdbw_pkg::LVL_LO +: 2];
  assign border_table_sel = border_q[epdbw_pkg::TBL_LO +: 2];
  assign read_ram_sel     = ramopt_q;
  assign x_window_start   = x_start_position_q;
  assign x_window_end     = x_end_position_q;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_border_load: assert property (ld_border |=>
      border_q == ($past(wdata_q) & epdbw_pkg::BORDER_MASK))
    else $error("border byte not latched");
  a_src_select: assert property (ld_border |=> border_drive_sel == $past(wdata_q[7:6]))
    else $error("border source wrong");
  a_fix_level: assert property (ld_border |=> border_fix_level == $past(wdata_q[5:4]))
    else $error("border level wrong");
  a_table_select: assert property (ld_border |=> border_table_sel == $past(wdata_q[1:0]))
    else $error("border table wrong");
  a_reset_values: assert property (disable iff (1'b0) !aresetn |=>
      border_q == epdbw_pkg::BORDER_RST && read_ram_sel == epdbw_pkg::RAMOPT_RST &&
      x_window_start == epdbw_pkg::X_START_POSITION_RST && x_window_end == epdbw_pkg::X_END_POSITION_RST)
    else $error("reset values wrong");
  a_ramopt_load: assert property (ld_ramopt |=> read_ram_sel == $past(wdata_q[0]))
    else $error("read ram option wrong");
  a_xwin_count: assert property (ld_xwin && idx_q == 3'h3 |=>
      state_q == epdbw_pkg::ST_IDLE)
    else $error("x window did not close after four bytes");
  a_x_start_position_high: assert property (ld_xwin && idx_q == 3'h1 |=>
      x_window_start[9:8] == $past(wdata_q[1:0]))
    else $error("x start high bits wrong");
  a_x_end_position_low: assert property (ld_xwin && idx_q == 3'h2 ##1 1'b1 |->
      x_window_end[7:0] == $past(wdata_q, 1))
    else $error("x end low byte wrong");
  a_opcode_restart: assert property (cmd_stb |=>
      idx_q == 3'h0 && state_q == op_decode($past(wdata_q)))
    else $error("opcode did not restart sequence");
  a_reserved_zero: assert property (border_q[3:2] == 2'b00)
    else $error("reserved border bits stored");
  a_resp_after: assert property (wr_fire |=>
      s_axi_bvalid [*1] ##0 !s_axi_awready && !s_axi_wready)
    else $error("write response missing");

  // Settings load byte by byte and hold between loads
  a_x_start_position_low: assert property (ld_xwin && idx_q == 3'h0 |=>
      x_window_start[7:0] == $past(wdata_q))
    else $error("x start low byte wrong");
  a_x_start_position_keep: assert property (ld_xwin && idx_q == 3'h0 |=>
      x_window_start[9:8] == $past(x_start_position_q[9:8]))
    else $error("x start high bits disturbed");
  a_x_end_position_high: assert property (ld_xwin && idx_q == 3'h3 |=>
      x_window_end[9:8] == $past(wdata_q[1:0]))
    else $error("x end high bits wrong");
  a_x_end_position_keep: assert property (ld_xwin && idx_q == 3'h2 |=>
      x_window_end[9:8] == $past(x_end_position_q[9:8]))
    else $error("x end high bits disturbed");
  a_border_hold: assert property (!ld_border |=> $stable(border_q))
    else $error("border setting changed without a load");
  a_ramopt_hold: assert property (!ld_ramopt |=> $stable(ramopt_q))
    else $error("read ram option changed without a load");
  a_xwin_hold: assert property (!ld_xwin |=> $stable(x_start_position_q) && $stable(x_end_position_q))
    else $error("x window changed without a load");
  a_idle_ignore: assert property (prm_stb && state_q == epdbw_pkg::ST_IDLE |=>
      $stable(border_q) && $stable(ramopt_q) && $stable(x_start_position_q) && $stable(x_end_position_q))
    else $error("stray parameter byte applied");
  a_cmd_keeps: assert property (cmd_stb |=> $stable(border_q) && $stable(ramopt_q))
    else $error("opcode disturbed a setting");

  // Sequencer and write channel
  a_border_open: assert property (cmd_stb && wdata_q == epdbw_pkg::OP_BORDER |=>
      state_q == epdbw_pkg::ST_BORDER)
    else $error("border opcode not decoded");
  a_ramopt_open: assert property (cmd_stb && wdata_q == epdbw_pkg::OP_RAMOPT |=>
      state_q == epdbw_pkg::ST_RAMOPT)
    else $error("read ram opcode not decoded");
  a_xwin_open: assert property (cmd_stb && wdata_q == epdbw_pkg::OP_XWIN |=>
      state_q == epdbw_pkg::ST_XWIN && idx_q == 3'h0)
    else $error("x window opcode not decoded");
  a_unknown_op: assert property (cmd_stb && wdata_q != epdbw_pkg::OP_BORDER &&
      wdata_q != epdbw_pkg::OP_RAMOPT && wdata_q != epdbw_pkg::OP_XWIN |=>
      state_q == epdbw_pkg::ST_IDLE)
    else $error("unknown opcode left sequencer busy");
  a_border_single: assert property (ld_border |=> state_q == epdbw_pkg::ST_IDLE)
    else $error("border took more than one byte");
  a_ramopt_single: assert property (ld_ramopt |=> state_q == epdbw_pkg::ST_IDLE)
    else $error("read ram option took more than one byte");
  a_idx_range: assert property (idx_q <= 3'(epdbw_pkg::XWIN_PRMS))
    else $error("byte index out of range");
  a_state_onehot: assert property ($onehot(state_q))
    else $error("sequencer state not one-hot");
  a_strobe_ignore: assert property (wr_fire && !wstrb0_q |=>
      $stable(state_q) && $stable(idx_q))
    else $error("write without byte strobe applied");
  a_write_slverr: assert property (wr_fire && !wr_ok |=>
      s_axi_bvalid && s_axi_bresp == epdbw_pkg::RESP_SLVERR)
    else $error("bad write address not refused");
  a_write_stall: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken before response");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_reset_state: assert property (disable iff (1'b0) !aresetn |=>
      state_q == epdbw_pkg::ST_IDLE && idx_q == 3'h0 && s_axi_awready && s_axi_arready &&
      !s_axi_bvalid && !s_axi_rvalid)
    else $error("sequencer or bus not reset");

  c_border_cmd: cover property (ld_border ##1 border_drive_sel == 2'b01);
  c_xwin_full: cover property (ld_xwin && idx_q == 3'h3);
  c_ramopt_set: cover property (ld_ramopt ##1 read_ram_sel);
  c_slverr_write: cover property (wr_fire && !wr_ok);
  c_stray_param: cover property (prm_stb && state_q == epdbw_pkg::ST_IDLE);

endmodule // epdbw_top

// >>> verilog/epdbw_pkg.sv
/*
  Constants for the border-control and RAM X-window command decoder:
  register offsets, opcodes, field positions, reset values and state codes.
  Assumes an AXI4-Lite master with 8-bit byte addresses and 32-bit data.
*/
// Summary of operation
// - Opcode 3C followed by one parameter byte loads the border control setting.
// - Bits 7:6 of that byte pick the border source: transition, fixed, common, open.
// - Bits 5:4 pick the fixed border level: ground, positive one, negative, positive two.
// - Bits 1:0 pick waveform table zero to three for the transition source.
// - After reset the border control setting is C0h, which leaves the output open.
// - Opcode 41 plus one byte selects readback RAM: bit 0 low the 24h RAM, high the 26h RAM.
// - Opcode 44 is followed by four parameter bytes latched as X window bounds.
// - X window start is ten bits from bytes one (low) and two (bits 9:8), reset 000h.
// - X window end is ten bits from bytes three (low) and four (bits 9:8), reset 3BFh.
package epdbw_pkg;
  localparam int unsigned AXI_AW = 8;
  // Register byte offsets
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_PARAM  = 8'h04;
  localparam logic [7:0] OFF_BORDER = 8'h08;
  localparam logic [7:0] OFF_RAMOPT = 8'h0c;
  localparam logic [7:0] OFF_XWIN   = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  // Opcodes
  localparam logic [7:0] OP_BORDER  = 8'h3c;
  localparam logic [7:0] OP_RAMOPT  = 8'h41;
  localparam logic [7:0] OP_XWIN    = 8'h44;
  // Border byte fields and reserved mask
  localparam int unsigned SRC_LO    = 6;
  localparam int unsigned LVL_LO    = 4;
  localparam int unsigned TBL_LO    = 0;
  localparam logic [7:0] BORDER_MASK = 8'hf3;
  // XWIN read layout: end field position
  localparam int unsigned X_END_POSITION_LO   = 16;
  localparam int unsigned XWIN_PRMS = 4;
  // Reset values
  localparam logic [7:0] BORDER_RST = 8'hc0;
  localparam logic       RAMOPT_RST = 1'b0;
  localparam logic [9:0] X_START_POSITION_RST = 10'h000;
  localparam logic [9:0] X_END_POSITION_RST   = 10'h3bf;
  // AXI responses
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_BORDER = 4'h2,
    ST_RAMOPT = 4'h4,
    ST_XWIN   = 4'h8
  } epdbw_state_e;
endpackage

// >>> tb/epdbw_host.sv
/* Host model: AXI4-Lite master with write and read tasks.
   Assumes one clock and a slave that answers each request. */
`timescale 1ns/1ps
module epdbw_host (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  logic [3:0] wr_strb = 4'hf;
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // Offset 00 carries opcodes, 04 parameters
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_open;
    logic w_open;
    aw_open = 1'b1;
    w_open = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= wr_strb;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_open || w_open) begin
      @(posedge aclk);
      if (aw_open && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
        aw_open = 1'b0;
      end
      if (w_open && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
        w_open = 1'b0;
      end
    end
    while (!bvalid) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    while (!arready) @(posedge aclk);
    arvalid <= 1'b0;
    araddr <= ~a;
    while (!rvalid) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule // epdbw_host

// >>> tb/test_epd_border_and_ram_window_cmds.sv
/* Testbench for the border, read-RAM and X window command decoder.
   Assumes the host model in epdbw_host drives the register bus. */
`timescale 1ns/1ps
module test_epd_border_and_ram_window_cmds;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, ram;
  logic [7:0]  awaddr, araddr, b;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, sel, lvl, tbl;
  logic [9:0]  xs, xe;
  logic [7:0]  xb [4] = '{8'h5a, 8'hfe, 8'hc3, 8'h01};
  int          n_errors, checks;
  epdbw_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .border_drive_sel(sel), .border_fix_level(lvl),
    .border_table_sel(tbl), .read_ram_sel(ram), .x_window_start(xs),
    .x_window_end(xe));
  epdbw_host i_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] r;
    i_host.wr(a, {24'h0, d}, r);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    i_host.rd(a, d, r);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic final_report;
    $display("Errors: %0d, checks: %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    final_report();
  end
  initial begin
    aresetn = 1'b0;
    n_errors = 0;
    checks = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({5'h0, sel, lvl, tbl, ram, xs, xe}, {5'h0, 7'h60, 10'h000, 10'h3bf});
    rchk(8'h08, 32'h0000_00c0, 2'h0);
    rchk(8'h10, 32'h03bf_0000, 2'h0);
    for (int i = 0; i < 4; i++) begin
      b = {i[1:0], ~i[1:0], 2'h3, i[1:0]};
      w(8'h00, 8'h3c, 2'h0);
      w(8'h04, b, 2'h0);
      chk({26'h0, sel, lvl, tbl}, {26'h0, b[7:4], b[1:0]});
      rchk(8'h08, {24'h0, b & 8'hf3}, 2'h0);
    end
    w(8'h00, 8'h41, 2'h0);
    w(8'h04, 8'hff, 2'h0);
    w(8'h04, 8'h00, 2'h0);
    chk({31'h0, ram}, 32'h1);
    rchk(8'h0c, 32'h1, 2'h0);
    w(8'h00, 8'h41, 2'h0);
    w(8'h04, 8'hfe, 2'h0);
    chk({31'h0, ram}, 32'h0);
    w(8'h00, 8'h44, 2'h0);
    for (int i = 0; i < 4; i++) w(8'h04, xb[i], 2'h0);
    w(8'h04, 8'h77, 2'h0);
    chk({12'h0, xs, xe}, {12'h0, 10'h25a, 10'h1c3});
    rchk(8'h10, 32'h01c3_025a, 2'h0);
    w(8'h00, 8'h44, 2'h0);
    w(8'h04, 8'h11, 2'h0);
    w(8'h00, 8'h3c, 2'h0);
    w(8'h04, 8'h40, 2'h0);
    chk({16'h0, xs, sel, lvl, tbl}, {16'h0, 10'h211, 6'h10});
    w(8'h08, 8'hc0, 2'h2);
    w(8'h18, 8'h00, 2'h2);
    chk({30'h0, sel}, 32'h1);
    rchk(8'h20, 32'h0, 2'h2);
    rchk(8'h14, 32'h0000_0011, 2'h0);
    rchk(8'h00, 32'h0, 2'h0);
    w(8'h00, 8'h3c, 2'h0);
    i_host.wr_strb = 4'he;
    w(8'h04, 8'h00, 2'h0);
    i_host.wr_strb = 4'hf;
    rchk(8'h14, 32'h0000_0002, 2'h0);
    w(8'h04, 8'h80, 2'h0);
    chk({30'h0, sel}, 32'h2);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({5'h0, sel, lvl, tbl, ram, xs, xe}, {5'h0, 7'h60, 10'h000, 10'h3bf});
    rchk(8'h14, 32'h0000_0001, 2'h0);
    final_report();
  end
endmodule // test_epd_border_and_ram_window_cmds
